/* File: include/ssw_pkg.sv */
// shared constants and carrier types of the stream switch
package ssw_pkg;

  // register map
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_MAX_XFER = 8'h04;
  localparam logic [7:0]  OFS_IDLE_LIM = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  OFS_RANGE    = 8'h10;
  localparam int          RANGE_SHIFT  = 3;

  // ctrl field positions
  localparam int          CTRL_MODE    = 0;
  localparam int          CTRL_LAST    = 1;
  localparam int          CTRL_COUNT   = 2;
  localparam int          CTRL_IDLE    = 3;
  localparam logic [3:0]  CTRL_RST     = 4'h3;

  // grant end limits
  localparam int          CNT_W        = 11;
  localparam logic [10:0] LIM_MIN      = 11'h004;
  localparam logic [10:0] LIM_MAX      = 11'h400;
  localparam logic [10:0] LIM_RST      = 11'h309;

  // destination range after reset: output j owns span*j .. span*j+span-1
  localparam logic [31:0] RANGE_SPAN   = 32'h0000_0002;

  // bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic {
    ARB_FIXED  = 1'b0,
    ARB_ROTATE = 1'b1
  } ssw_arb_e;

  typedef enum logic {
    GNT_IDLE = 1'b0,
    GNT_HOLD = 1'b1
  } ssw_gnt_e;

  typedef struct packed {
    ssw_arb_e          mode;
    logic              en_last;
    logic              en_count;
    logic              en_idle;
    logic [CNT_W-1:0]  max_xfer;
    logic [CNT_W-1:0]  idle_lim;
  } ssw_cfg_s;

endpackage

/* File: verilog/ssw_arb.sv */
// per-output arbiter with grant hold and end conditions
`timescale 1ns/1ps
`default_nettype none
module ssw_arb #(
  parameter int NS = 2
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst_n,
  // configuration
  input  wire ssw_pkg::ssw_cfg_s  cfg,
  // requests and traffic of this output
  input  wire logic [NS-1:0]      req,
  input  wire logic [NS-1:0]      src_valid,
  input  wire logic               beat,
  input  wire logic               beat_last,
  // grant
  output logic [NS-1:0]           gnt_d,
  output logic [NS-1:0]           gnt_q
);

  localparam int PW = (NS > 1) ? $clog2(NS) : 1;

  typedef struct packed {
    ssw_pkg::ssw_gnt_e        st;
    logic [NS-1:0]            gnt;
    logic [PW-1:0]            last;
    logic                     first;
    logic [ssw_pkg::CNT_W-1:0] cnt;
    logic [ssw_pkg::CNT_W-1:0] idle;
  } ssw_arb_st_s;

  localparam ssw_arb_st_s ST_RST = '{st: ssw_pkg::GNT_IDLE, gnt: '0, last: '0, first: 1'b1, cnt: '0, idle: '0};

  ssw_arb_st_s s_q;
  ssw_arb_st_s s_d;

  always_comb begin
    logic [NS-1:0]             pick;
    logic [PW-1:0]             pidx;
    logic                      found;
    logic                      gvalid;
    logic                      done;
    logic [ssw_pkg::CNT_W-1:0] cnt_inc;
    logic [ssw_pkg::CNT_W-1:0] idle_inc;
    int                        base;
    int                        idx;
    pick     = '0;
    pidx     = '0;
    found    = 1'b0;
    gvalid   = 1'b0;
    done     = 1'b0;
    cnt_inc  = '0;
    idle_inc = '0;
    base     = 0;
    idx      = 0;
    s_d      = s_q;
    // fixed mode: highest request wins
    if (cfg.mode == ssw_pkg::ARB_FIXED) begin
      for (int k = NS - 1; k >= 0; k--) begin
        if (!found && req[k]) begin
          pick[k] = 1'b1;
          pidx    = PW'(k);
          found   = 1'b1;
        end
      end
    end else begin
      // search downward from the last served, top first after reset
      base = s_q.first ? NS : int'(s_q.last);
      for (int k = 1; k <= NS; k++) begin
        idx = (base + NS - k) % NS;
        if (!found && req[idx]) begin
          pick[idx] = 1'b1;
          pidx      = PW'(idx);
          found     = 1'b1;
        end
      end
    end
    case (s_q.st)
      ssw_pkg::GNT_IDLE: begin
        if (found) begin
          s_d.st    = ssw_pkg::GNT_HOLD;
          s_d.gnt   = pick;
          s_d.last  = pidx;
          s_d.first = 1'b0;
          s_d.cnt   = '0;
          s_d.idle  = '0;
        end
      end
      ssw_pkg::GNT_HOLD: begin
        gvalid   = |(s_q.gnt & src_valid);
        cnt_inc  = s_q.cnt + ssw_pkg::CNT_W'(1);
        idle_inc = gvalid ? ssw_pkg::CNT_W'(0) : s_q.idle + ssw_pkg::CNT_W'(1);
        if (beat && s_q.cnt != '1) begin
          s_d.cnt = cnt_inc;
        end
        if (s_q.idle != '1) begin
          s_d.idle = idle_inc;
        end
        if (cfg.en_last && beat && beat_last) begin
          done = 1'b1;
        end
        if (cfg.en_count && beat && cnt_inc >= cfg.max_xfer) begin
          done = 1'b1;
        end
        if (cfg.en_idle && !gvalid && idle_inc >= cfg.idle_lim) begin
          done = 1'b1;
        end
        if (done) begin
          s_d.st  = ssw_pkg::GNT_IDLE;
          s_d.gnt = '0;
        end
      end
      default: begin
        s_d = ST_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign gnt_d = s_d.gnt;
  assign gnt_q = s_q.gnt;

endmodule
`default_nettype wire

/* File: verilog/ssw_switch.sv */
// stream crossbar top with routing, output slots and register slave
// What this block does
// - one to eight inputs and outputs, parameterised
// - single clock, async active-low reset
// - decode each beat's destination to pick output
// - grant exactly one contender per output
// - ready only on the granted input
// - beat moves when valid and ready high
// - output beat held until sink ready
// - grant released after maximum transfer count
// - grant released after idle valid limit
// - fixed mode grants highest requesting port
// - rotating mode searches downward, wraps, starts top
// - data buses whole bytes, qualifiers per byte
// - keep passes through unchanged
// - dest, id, user, strobe copied with data
// - packet boundary flag forwarded
// - each output owns inclusive destination range
// - transfer and idle limits 4 to 1024
// - dest 1-10, id 0-32, user 0-4096 bits
// - disjoint paths transfer concurrently
`timescale 1ns/1ps
`default_nettype none
module ssw_switch #(
  parameter int NS     = 2,
  parameter int NM     = 2,
  parameter int BYTES  = 1,
  parameter int DEST_W = 2,
  parameter int ID_W   = 0,
  parameter int USER_W = 0
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst_n,
  // upstream stream ports
  input  wire logic [NS*BYTES*8-1:0]     s_axis_tdata,
  input  wire logic [NS*BYTES-1:0]       s_axis_tstrb,
  input  wire logic [NS*BYTES-1:0]       s_axis_tkeep,
  input  wire logic [NS*DEST_W-1:0]      s_axis_tdest,
  input  wire logic [NS*((USER_W > 0) ? USER_W : 1)-1:0] s_axis_tuser,
  input  wire logic [NS*((ID_W > 0) ? ID_W : 1)-1:0]     s_axis_tid,
  input  wire logic [NS-1:0]             s_axis_tvalid,
  input  wire logic [NS-1:0]             s_axis_tlast,
  output logic [NS-1:0]                  s_axis_tready,
  // downstream stream ports
  output logic [NM-1:0]                  m_axis_tvalid,
  output logic [NM*BYTES*8-1:0]          m_axis_tdata,
  output logic [NM*BYTES-1:0]            m_axis_tstrb,
  output logic [NM*BYTES-1:0]            m_axis_tkeep,
  output logic [NM*DEST_W-1:0]           m_axis_tdest,
  output logic [NM*((USER_W > 0) ? USER_W : 1)-1:0]      m_axis_tuser,
  output logic [NM*((ID_W > 0) ? ID_W : 1)-1:0]          m_axis_tid,
  output logic [NM-1:0]                  m_axis_tlast,
  input  wire logic [NM-1:0]             m_axis_tready,
  // register slave
  input  wire logic [7:0]                s_axil_awaddr,
  input  wire logic                      s_axil_awvalid,
  output logic                           s_axil_awready,
  input  wire logic [31:0]               s_axil_wdata,
  input  wire logic [3:0]                s_axil_wstrb,
  input  wire logic                      s_axil_wvalid,
  output logic                           s_axil_wready,
  output logic [1:0]                     s_axil_bresp,
  output logic                           s_axil_bvalid,
  input  wire logic                      s_axil_bready,
  input  wire logic [7:0]                s_axil_araddr,
  input  wire logic                      s_axil_arvalid,
  output logic                           s_axil_arready,
  output logic [31:0]                    s_axil_rdata,
  output logic [1:0]                     s_axil_rresp,
  output logic                           s_axil_rvalid,
  input  wire logic                      s_axil_rready
);

  // beat layout: data, strobe, keep, dest, id, user, last
  localparam int IW  = (ID_W > 0) ? ID_W : 1;
  localparam int UW  = (USER_W > 0) ? USER_W : 1;
  localparam int D8  = BYTES * 8;
  localparam int OS  = D8;
  localparam int OK  = OS + BYTES;
  localparam int ODS = OK + BYTES;
  localparam int OI  = ODS + DEST_W;
  localparam int OU  = OI + IW;
  localparam int OL  = OU + UW;
  localparam int BW  = OL + 1;

  typedef struct packed {
    logic [NM-1:0]              ov;
    logic [NM-1:0][BW-1:0]      ob;
    logic [NS-1:0]              rdy;
    ssw_pkg::ssw_cfg_s          cfg;
    logic [NM-1:0][1:0][31:0]   rng;
    logic                       aw_got;
    logic                       w_got;
    logic [7:0]                 awaddr;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } ssw_top_st_s;

  function automatic ssw_top_st_s rst_state();
    ssw_top_st_s r;
    r              = '0;
    r.cfg.mode     = ssw_pkg::ssw_arb_e'(ssw_pkg::CTRL_RST[ssw_pkg::CTRL_MODE]);
    r.cfg.en_last  = ssw_pkg::CTRL_RST[ssw_pkg::CTRL_LAST];
    r.cfg.en_count = ssw_pkg::CTRL_RST[ssw_pkg::CTRL_COUNT];
    r.cfg.en_idle  = ssw_pkg::CTRL_RST[ssw_pkg::CTRL_IDLE];
    r.cfg.max_xfer = ssw_pkg::LIM_RST;
    r.cfg.idle_lim = ssw_pkg::LIM_RST;
    for (int j = 0; j < NM; j++) begin
      r.rng[j][0] = 32'(j) * ssw_pkg::RANGE_SPAN;
      r.rng[j][1] = 32'(j) * ssw_pkg::RANGE_SPAN + ssw_pkg::RANGE_SPAN - 32'h0000_0001;
    end
    r.awready      = 1'b1;
    r.wready       = 1'b1;
    r.arready      = 1'b1;
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [10:0] clamp(input logic [31:0] v);
    logic [10:0] r;
    if (v < 32'(ssw_pkg::LIM_MIN)) begin
      r = ssw_pkg::LIM_MIN;
    end else if (v > 32'(ssw_pkg::LIM_MAX)) begin
      r = ssw_pkg::LIM_MAX;
    end else begin
      r = v[10:0];
    end
    return r;
  endfunction

  localparam ssw_top_st_s ST_RST = rst_state();

  ssw_top_st_s         s_q;
  ssw_top_st_s         s_d;
  logic [BW-1:0]       bin   [NS];
  logic [NS-1:0]       hs;
  logic [NS-1:0]       req   [NM];
  logic [NS-1:0]       gnt_d [NM];
  logic [NS-1:0]       gnt_q [NM];
  logic [NM-1:0]       beat;
  logic [NM-1:0]       blast;
  logic [BW-1:0]       bmux  [NM];

  // routing and grant muxing
  always_comb begin
    logic [31:0]   dst;
    logic          hit;
    logic [NS-1:0] held;
    dst  = '0;
    hit  = 1'b0;
    held = '0;
    for (int k = 0; k < NS; k++) begin
      bin[k] = {s_axis_tlast[k], s_axis_tuser[k*UW +: UW], s_axis_tid[k*IW +: IW],
                s_axis_tdest[k*DEST_W +: DEST_W], s_axis_tkeep[k*BYTES +: BYTES],
                s_axis_tstrb[k*BYTES +: BYTES], s_axis_tdata[k*D8 +: D8]};
    end
    hs = s_q.rdy & s_axis_tvalid;
    for (int j = 0; j < NM; j++) begin
      held = held | gnt_q[j];
      req[j] = '0;
    end
    for (int k = 0; k < NS; k++) begin
      dst = 32'(s_axis_tdest[k*DEST_W +: DEST_W]);
      hit = 1'b0;
      for (int j = 0; j < NM; j++) begin
        if (!hit && dst >= s_q.rng[j][0] && dst <= s_q.rng[j][1]) begin
          hit       = 1'b1;
          req[j][k] = s_axis_tvalid[k] & ~held[k];
        end
      end
    end
    for (int j = 0; j < NM; j++) begin
      bmux[j] = '0;
      for (int k = 0; k < NS; k++) begin
        if (gnt_q[j][k]) begin
          bmux[j] = bmux[j] | bin[k];
        end
      end
      beat[j]  = |(gnt_q[j] & hs);
      blast[j] = bmux[j][OL];
    end
  end

  // state update: output slots, ready, register slave
  always_comb begin
    logic [7:0]  wa;
    logic [7:0]  ra;
    logic [7:0]  ri;
    logic [15:0] stat;
    wa   = '0;
    ra   = '0;
    ri   = '0;
    stat = '0;
    s_d  = s_q;
    for (int j = 0; j < NM; j++) begin
      if (s_q.ov[j] && m_axis_tready[j]) begin
        s_d.ov[j] = 1'b0;
      end
      if (beat[j]) begin
        s_d.ov[j] = 1'b1;
        s_d.ob[j] = bmux[j];
      end
    end
    for (int k = 0; k < NS; k++) begin
      s_d.rdy[k] = 1'b0;
      for (int j = 0; j < NM; j++) begin
        if (gnt_d[j][k] && !s_d.ov[j]) begin
          s_d.rdy[k] = 1'b1;
        end
      end
    end
    // write channel
    if (s_axil_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axil_wdata;
      s_d.wstrb = s_axil_wstrb;
    end
    if (s_q.bvalid && s_axil_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      wa         = {s_q.awaddr[7:2], 2'h0};
      ri         = (wa - ssw_pkg::OFS_RANGE) >> ssw_pkg::RANGE_SHIFT;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = ssw_pkg::RESP_OKAY;
      if (wa == ssw_pkg::OFS_CTRL) begin
        if (s_q.wstrb[0]) begin
          s_d.cfg.mode     = ssw_pkg::ssw_arb_e'(s_q.wdata[ssw_pkg::CTRL_MODE]);
          s_d.cfg.en_last  = s_q.wdata[ssw_pkg::CTRL_LAST];
          s_d.cfg.en_count = s_q.wdata[ssw_pkg::CTRL_COUNT];
          s_d.cfg.en_idle  = s_q.wdata[ssw_pkg::CTRL_IDLE];
        end
      end else if (wa == ssw_pkg::OFS_MAX_XFER) begin
        s_d.cfg.max_xfer = clamp(merge(32'(s_q.cfg.max_xfer), s_q.wdata, s_q.wstrb));
      end else if (wa == ssw_pkg::OFS_IDLE_LIM) begin
        s_d.cfg.idle_lim = clamp(merge(32'(s_q.cfg.idle_lim), s_q.wdata, s_q.wstrb));
      end else if (wa == ssw_pkg::OFS_STATUS) begin
        s_d.bresp = ssw_pkg::RESP_OKAY;
      end else if (wa >= ssw_pkg::OFS_RANGE && 32'(ri) < 32'(NM)) begin
        s_d.rng[ri][wa[2]] = merge(s_q.rng[ri][wa[2]], s_q.wdata, s_q.wstrb);
      end else begin
        s_d.bresp = ssw_pkg::RESP_SLVERR;
      end
    end
    s_d.awready = !s_d.aw_got;
    s_d.wready  = !s_d.w_got;
    // read channel
    if (s_q.rvalid && s_axil_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
    if (s_axil_arvalid && s_q.arready) begin
      ra          = {s_axil_araddr[7:2], 2'h0};
      ri          = (ra - ssw_pkg::OFS_RANGE) >> ssw_pkg::RANGE_SHIFT;
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = ssw_pkg::RESP_OKAY;
      s_d.rdata   = '0;
      for (int j = 0; j < NM; j++) begin
        stat[j]     = |gnt_q[j];
        stat[8 + j] = s_q.ov[j];
      end
      if (ra == ssw_pkg::OFS_CTRL) begin
        s_d.rdata[ssw_pkg::CTRL_MODE]  = s_q.cfg.mode;
        s_d.rdata[ssw_pkg::CTRL_LAST]  = s_q.cfg.en_last;
        s_d.rdata[ssw_pkg::CTRL_COUNT] = s_q.cfg.en_count;
        s_d.rdata[ssw_pkg::CTRL_IDLE]  = s_q.cfg.en_idle;
      end else if (ra == ssw_pkg::OFS_MAX_XFER) begin
        s_d.rdata = 32'(s_q.cfg.max_xfer);
      end else if (ra == ssw_pkg::OFS_IDLE_LIM) begin
        s_d.rdata = 32'(s_q.cfg.idle_lim);
      end else if (ra == ssw_pkg::OFS_STATUS) begin
        s_d.rdata = 32'(stat);
      end else if (ra >= ssw_pkg::OFS_RANGE && 32'(ri) < 32'(NM)) begin
        s_d.rdata = s_q.rng[ri][ra[2]];
      end else begin
        s_d.rresp = ssw_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // one arbiter and output lane per downstream port
  for (genvar j = 0; j < NM; j++) begin : g_out
    ssw_arb #(
      .NS (NS)
    ) u_arb (
      .core_clk  (core_clk),
      .sys_rst_n (sys_rst_n),
      .cfg       (s_q.cfg),
      .req       (req[j]),
      .src_valid (s_axis_tvalid),
      .beat      (beat[j]),
      .beat_last (blast[j]),
      .gnt_d     (gnt_d[j]),
      .gnt_q     (gnt_q[j])
    );
    assign m_axis_tvalid[j]                 = s_q.ov[j];
    assign m_axis_tdata[j*D8 +: D8]         = s_q.ob[j][D8-1:0];
    assign m_axis_tstrb[j*BYTES +: BYTES]   = s_q.ob[j][OS +: BYTES];
    assign m_axis_tkeep[j*BYTES +: BYTES]   = s_q.ob[j][OK +: BYTES];
    assign m_axis_tdest[j*DEST_W +: DEST_W] = s_q.ob[j][ODS +: DEST_W];
    assign m_axis_tid[j*IW +: IW]           = s_q.ob[j][OI +: IW];
    assign m_axis_tuser[j*UW +: UW]         = s_q.ob[j][OU +: UW];
    assign m_axis_tlast[j]                  = s_q.ob[j][OL];
  end

  assign s_axis_tready  = s_q.rdy;
  assign s_axil_awready = s_q.awready;
  assign s_axil_wready  = s_q.wready;
  assign s_axil_bvalid  = s_q.bvalid;
  assign s_axil_bresp   = s_q.bresp;
  assign s_axil_arready = s_q.arready;
  assign s_axil_rvalid  = s_q.rvalid;
  assign s_axil_rdata   = s_q.rdata;
  assign s_axil_rresp   = s_q.rresp;

endmodule
`default_nettype wire

/* File: testbench/ssw_monitor.sv */
// port checker of the stream switch
`timescale 1ns/1ps
`default_nettype none
module ssw_monitor #(
  parameter int NS     = 2,
  parameter int NM     = 2,
  parameter int BYTES  = 1,
  parameter int DEST_W = 2
) (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  sys_rst_n,
  // upstream
  input wire logic [NS*BYTES*8-1:0] s_axis_tdata,
  input wire logic [NS*BYTES-1:0]   s_axis_tkeep,
  input wire logic [NS*BYTES-1:0]   s_axis_tstrb,
  input wire logic [NS*DEST_W-1:0]  s_axis_tdest,
  input wire logic [NS-1:0]         s_axis_tvalid,
  input wire logic [NS-1:0]         s_axis_tlast,
  input wire logic [NS-1:0]         s_axis_tready,
  // downstream
  input wire logic [NM*BYTES*8-1:0] m_axis_tdata,
  input wire logic [NM*BYTES-1:0]   m_axis_tkeep,
  input wire logic [NM*BYTES-1:0]   m_axis_tstrb,
  input wire logic [NM*DEST_W-1:0]  m_axis_tdest,
  input wire logic [NM-1:0]         m_axis_tvalid,
  input wire logic [NM-1:0]         m_axis_tlast,
  input wire logic [NM-1:0]         m_axis_tready,
  // read channel
  input wire logic                  s_axil_arvalid,
  input wire logic                  s_axil_arready,
  input wire logic                  s_axil_rvalid
);
  localparam int W = BYTES * 8, B = BYTES, D = DEST_W;
  logic [NS-1:0] hit [NM];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!sys_rst_n);
  sequence s_take(k);
    s_axis_tvalid[k] && s_axis_tready[k];
  endsequence
  sequence s_drain(j);
    m_axis_tvalid[j] && m_axis_tready[j];
  endsequence
  // accepted beats per output, reset ranges
  always_comb begin
    for (int j = 0; j < NM; j++) begin
      for (int k = 0; k < NS; k++) begin
        hit[j][k] = s_axis_tvalid[k] & s_axis_tready[k] & (s_axis_tdest[k*D+:D] / ssw_pkg::RANGE_SPAN == j);
      end
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0)
    !sys_rst_n ##1 !sys_rst_n |-> !{m_axis_tvalid, s_axis_tready, s_axil_rvalid})
    else $error("active in reset");
  a_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read data late");
  for (genvar k = 0; k < NS; k++) begin : g_src
    a_ready_drop: assert property (s_take(k) |=> !s_axis_tready[k])
      else $error("ready held");
  end
  for (genvar j = 0; j < NM; j++) begin : g_out
    a_one_winner: assert property ($countones(hit[j]) <= 1)
      else $error("two winners");
    a_out_hold: assert property (m_axis_tvalid[j] && !m_axis_tready[j] |=>
      m_axis_tvalid[j] && $stable({m_axis_tdata[j*W+:W], m_axis_tlast[j]}))
      else $error("beat changed early");
    a_drain_clear: assert property (s_drain(j) |=> !m_axis_tvalid[j])
      else $error("slot not emptied");
    a_no_spurious: assert property ($rose(m_axis_tvalid[j]) |-> $past(|hit[j]))
      else $error("spurious valid");
    for (genvar k = 0; k < NS; k++) begin : g_in
      a_route_beat: assert property (hit[j][k] |=> m_axis_tvalid[j] &&
        {m_axis_tdata[j*W+:W], m_axis_tlast[j], m_axis_tkeep[j*B+:B], m_axis_tstrb[j*B+:B], m_axis_tdest[j*D+:D]} ==
        $past({s_axis_tdata[k*W+:W], s_axis_tlast[k], s_axis_tkeep[k*B+:B], s_axis_tstrb[k*B+:B], s_axis_tdest[k*D+:D]}))
        else $error("beat corrupted");
    end
  end
endmodule
`default_nettype wire

/* File: testbench/ssw_sink_model.sv */
// downstream sink model, prompt or stalling
`timescale 1ns/1ps
`default_nettype none
module ssw_sink_model #(
  parameter int NM = 2
) (
  // clock and reset
  input wire logic          core_clk,
  input wire logic          sys_rst_n,
  // stream side
  input wire logic [NM-1:0] m_axis_tvalid,
  output logic [NM-1:0]     m_axis_tready,
  // pacing
  input wire logic          slow
);
  logic [3:0] tick_q;
  always @(posedge core_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      tick_q        <= 4'h0;
      m_axis_tready <= '0;
    end else begin
      tick_q <= tick_q + 4'h1;
      for (int j = 0; j < NM; j++) begin
        m_axis_tready[j] <= !slow || (tick_q[1:0] == 2'(j));
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench of the stream switch
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk;
  logic        sys_rst_n;
  logic        slow;
  logic        both_seen;
  logic [15:0] s_axis_tdata, m_axis_tdata;
  logic [3:0]  s_axis_tdest, m_axis_tdest, s_axil_wstrb;
  logic [1:0]  s_axis_tstrb, s_axis_tkeep, s_axis_tuser, s_axis_tid, s_axis_tvalid, s_axis_tlast, s_axis_tready;
  logic [1:0]  m_axis_tstrb, m_axis_tkeep, m_axis_tuser, m_axis_tid, m_axis_tvalid, m_axis_tlast, m_axis_tready;
  logic [7:0]  s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata, rd_d;
  logic [1:0]  s_axil_bresp, s_axil_rresp, rd_r;
  logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid, s_axil_bready;
  logic        s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  logic [10:0] h;
  logic [10:0] sq[2][$];
  logic [8:0]  got[2][$];
  logic [8:0]  exq[2][$];
  int          n_fail;
  int          total_checks;

  ssw_switch DUT (.*);
  ssw_sink_model u_sink (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // sources hold beat until taken
  always @(posedge core_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (s_axis_tvalid[k] && s_axis_tready[k]) begin
        void'(sq[k].pop_front());
      end
      if (sq[k].size() > 0) begin
        h = sq[k][0];
        s_axis_tvalid[k]     <= 1'b1;
        s_axis_tdata[8*k+:8] <= h[7:0];
        s_axis_tlast[k]      <= h[8];
        s_axis_tdest[2*k+:2] <= h[10:9];
        s_axis_tkeep[k]      <= h[0];
        s_axis_tstrb[k]      <= h[1];
        s_axis_tuser[k]      <= h[2];
        s_axis_tid[k]        <= h[3];
      end else begin
        s_axis_tvalid[k]     <= 1'b0;
        s_axis_tdata[8*k+:8] <= ~s_axis_tdata[8*k+:8];
      end
    end
  end

  // collector of delivered beats
  always @(posedge core_clk) begin
    for (int j = 0; j < 2; j++) begin
      if (m_axis_tvalid[j] && m_axis_tready[j]) begin
        got[j].push_back({m_axis_tlast[j], m_axis_tdata[8*j+:8]});
        chk("side", m_axis_tdata[8*j+2+:2], {m_axis_tid[j], m_axis_tuser[j]});
      end
    end
    if (m_axis_tvalid == 2'b11) begin
      both_seen <= 1'b1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {s_axil_awaddr, s_axil_wdata} <= {a, d};
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (!s_axil_bvalid);
    s_axil_bready <= 1'b0;
    chk("bresp", ssw_pkg::RESP_OKAY, s_axil_bresp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axil_araddr <= a;
    {s_axil_arvalid, s_axil_rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (!s_axil_rvalid);
    {d, r} = {s_axil_rdata, s_axil_rresp};
    s_axil_rready <= 1'b0;
  endtask

  task automatic pk(input int k, d, n, b, input bit l);
    for (int i = 0; i < n; i++) begin
      sq[k].push_back({2'(d), l && i == n - 1, 8'(b + i)});
    end
  endtask

  task automatic ex(input int j, b, n, input bit l);
    for (int i = 0; i < n; i++) begin
      exq[j].push_back({l && i == n - 1, 8'(b + i)});
    end
  endtask

  task automatic run_case(input string nm);
    do begin
      @(negedge core_clk);
    end while (sq[0].size() + sq[1].size() > 0 || m_axis_tvalid !== 2'b00);
    for (int j = 0; j < 2; j++) begin
      chk({nm, " size"}, exq[j].size(), got[j].size());
      while (exq[j].size() && got[j].size()) begin
        chk(nm, exq[j].pop_front(), got[j].pop_front());
      end
      exq[j].delete();
      got[j].delete();
    end
    $display("test %s done", nm);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end

  initial begin
    logic [31:0] regs[8];
    regs = '{32'h3, 32'h309, 32'h309, 32'h0, 32'h0, 32'h1, 32'h2, 32'h3};
    {sys_rst_n, slow, both_seen, s_axis_tdata, s_axis_tdest, s_axis_tstrb, s_axis_tkeep} = '0;
    {s_axis_tuser, s_axis_tid, s_axis_tvalid, s_axis_tlast, s_axil_awaddr, s_axil_awvalid} = '0;
    {s_axil_wdata, s_axil_wvalid, s_axil_bready, s_axil_araddr, s_axil_arvalid, s_axil_rready} = '0;
    s_axil_wstrb = 4'hF;
    repeat (20) @(posedge core_clk);
    sys_rst_n <= 1'b1;
    foreach (regs[i]) begin
      rd(8'(4 * i), rd_d, rd_r);
      chk("reg reset", regs[i], rd_d);
    end
    rd(8'h40, rd_d, rd_r);
    chk("unmapped", ssw_pkg::RESP_SLVERR, rd_r);
    wr(8'h04, 32'h2);
    rd(8'h04, rd_d, rd_r);
    chk("xfer clamp", 32'h4, rd_d);
    wr(8'h08, 32'h7D0);
    rd(8'h08, rd_d, rd_r);
    chk("idle clamp", 32'h400, rd_d);
    $display("test registers done");
    slow <= 1'b1;
    @(negedge core_clk);
    pk(0, 0, 2, 'h10, 1);
    pk(0, 0, 2, 'h20, 1);
    pk(1, 1, 2, 'h30, 1);
    pk(1, 1, 2, 'h40, 1);
    ex(0, 'h30, 2, 1);
    ex(0, 'h10, 2, 1);
    ex(0, 'h40, 2, 1);
    ex(0, 'h20, 2, 1);
    run_case("rotate last");
    wr(8'h00, 32'h2);
    slow <= 1'b0;
    @(negedge core_clk);
    pk(0, 0, 2, 'h50, 1);
    pk(0, 0, 2, 'h60, 1);
    pk(1, 0, 2, 'h70, 1);
    pk(1, 1, 2, 'h80, 1);
    ex(0, 'h70, 2, 1);
    ex(0, 'h80, 2, 1);
    ex(0, 'h50, 2, 1);
    ex(0, 'h60, 2, 1);
    run_case("fixed");
    wr(8'h08, 32'h4);
    wr(8'h00, 32'hD);
    @(negedge core_clk);
    pk(0, 0, 6, 'h90, 0);
    pk(1, 0, 6, 'hA0, 0);
    ex(0, 'hA0, 4, 0);
    ex(0, 'h90, 4, 0);
    ex(0, 'hA4, 2, 0);
    ex(0, 'h94, 2, 0);
    run_case("count idle");
    wr(8'h00, 32'h3);
    slow <= 1'b1;
    @(negedge core_clk);
    pk(0, 3, 3, 'hB0, 1);
    pk(1, 0, 3, 'hC0, 1);
    ex(1, 'hB0, 3, 1);
    ex(0, 'hC0, 3, 1);
    run_case("parallel");
    chk("both busy", 32'h1, both_seen);
    @(negedge core_clk);
    pk(1, 2, 4, 'hD0, 1);
    wait (m_axis_tvalid[1] === 1'b1);
    @(posedge core_clk);
    sys_rst_n <= 1'b0;
    #1;
    chk("reset outputs", 32'h0, {m_axis_tvalid, s_axis_tready});
    sq[1].delete();
    got[1].delete();
    repeat (20) @(posedge core_clk);
    sys_rst_n <= 1'b1;
    rd(8'h04, rd_d, rd_r);
    chk("xfer after reset", 32'h309, rd_d);
    $display("test reset done");
    end_sim();
  end
endmodule

bind ssw_switch ssw_monitor #(.NS(NS), .NM(NM), .BYTES(BYTES), .DEST_W(DEST_W)) u_mon (.*);
`default_nettype wire
